// [design/qpss_coil_scale.sv]
`timescale 1ns/10ps
// Scales one coil current from the sine table by the duty-cycle sum.
module qpss_coil_scale #(
  parameter int CW = 9, // Coil current width.
  parameter int DW = 10 // Duty-cycle sum width.
) (
  input wire logic clk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [CW-1:0] cur_i, // Coil current from the table.
  input wire logic [DW-1:0] duty_i, // Duty-cycle sum.
  output logic [CW-1:0] scaled_o // Scaled coil current.
);
  logic [CW+DW-1:0] nxt_product;

  // Full duty leaves the current almost unchanged; dropping the low
  // bits keeps the output the same width as the table entry.
  assign nxt_product = cur_i * duty_i; // RULE3

  // The product is registered so that the top output is a flop.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scaled_o <= '0;
    end else begin
      scaled_o <= nxt_product[CW+DW-1:DW]; // RULE3
    end
  end

  a_scale_product: assert property ( // RULE3
    @(posedge clk_i) disable iff (!rstn_i)
    rstn_i |=> scaled_o == ((CW+DW)'($past(cur_i)) * $past(duty_i)) >> DW
  ) else $error("coil scale does not follow current times duty");

endmodule : qpss_coil_scale

// [design/qpss_consts.svh]
`ifndef QPSS_CONSTS_SVH
`define QPSS_CONSTS_SVH

// Register indexes; the byte address is four times the index.
`define QPSS_IDX_SCALE 10'h072
`define QPSS_IDX_AUTO 10'h073
`define QPSS_IDX_STALL 10'h074
`define QPSS_IDX_RESULT 10'h075
`define QPSS_IDX_SAMPLES 10'h076

// Field positions of the scale status register.
`define QPSS_SCALE_AUTO_MSB 24
`define QPSS_SCALE_AUTO_LSB 16
`define QPSS_SUM_MSB 9
`define QPSS_SUM_LSB 0

// Field positions of the auto tuning status register.
`define QPSS_GRAD_MSB 23
`define QPSS_GRAD_LSB 16
`define QPSS_OFS_MSB 7
`define QPSS_OFS_LSB 0

// Field positions of the stall detection setup register.
`define QPSS_PHASE_BIT 9
`define QPSS_FILT_BIT 8
`define QPSS_THR_MSB 7
`define QPSS_THR_LSB 0

// Field positions of the load result register.
`define QPSS_RESULT_MSB 9
`define QPSS_RESULT_LSB 0

// Byte lanes that carry the writable fields.
`define QPSS_LANE_THR 0
`define QPSS_LANE_CTRL 1

// Reset values.
`define QPSS_PHASE_RST 1'b1
`define QPSS_FILT_RST 1'b0
`define QPSS_THR_RST 8'h00
`define QPSS_STATUS_RST 32'h0000_0000
`define QPSS_RESULT_RST 10'h000
`define QPSS_SAMPLE_RST 8'h00

// Largest duty-cycle sum, which means full duty.
`define QPSS_DUTY_MAX 10'h3ff

`endif

// [design/qpss_load_stall.sv]
`timescale 1ns/10ps
`include "qpss_consts.svh"
// Captures the load result each full step and flags a stall.
module qpss_load_stall
  import qpss_pkg::*;
(
  input wire logic clk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  qpss_stall_if.det st // Setup in, result and stall out.
);
  qpss_load_t nxt_sum;

  // The current 8-bit sample and the three newest stored samples sum to a
  // full 10-bit result, so the filtered value keeps the scale of the raw measurement.
  assign nxt_sum = qpss_load_t'({2'b00, st.measure[9:2]}) +
                   qpss_load_t'({2'b00, st.samples[0]}) +
                   qpss_load_t'({2'b00, st.samples[1]}) +
                   qpss_load_t'({2'b00, st.samples[2]});

  // Filter sample history, shifted once per full step while the filter is on.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) begin
        st.samples[i] <= `QPSS_SAMPLE_RST;
      end
    end else if (st.full_step && st.filt_en) begin // RULE12
      st.samples[0] <= st.measure[9:2];
      for (int i = 1; i < 4; i++) begin
        st.samples[i] <= st.samples[i-1];
      end
    end
  end

  // Result updates on every full step, whatever the threshold.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st.result <= `QPSS_RESULT_RST;
    end else if (st.full_step) begin // RULE11
      st.result <= st.filt_en ? nxt_sum : st.measure; // RULE8
    end
  end

  // Stall is a level that follows the latest result.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st.stall <= 1'b0;
    end else begin
      st.stall <= (st.result <= {2'b00, st.threshold}); // RULE10
    end
  end

  a_result_update: assert property ( // RULE11
    @(posedge clk_i) disable iff (!rstn_i)
    st.full_step && !st.filt_en |=> st.result == $past(st.measure)
  ) else $error("load result not taken on full step");

  a_result_hold: assert property ( // RULE11
    @(posedge clk_i) disable iff (!rstn_i)
    !st.full_step |=> $stable(st.result)
  ) else $error("load result changed between full steps");

  a_stall_compare: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rstn_i)
    rstn_i |=> st.stall == ($past(st.result) <= {2'b00, $past(st.threshold)})
  ) else $error("stall does not match result against threshold");

endmodule : qpss_load_stall

// [design/qpss_pkg.sv]
package qpss_pkg;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    QPSS_ST_IDLE = 2'b01,
    QPSS_ST_RESP = 2'b10
  } qpss_apb_st_t;

  // One load measurement sample fed into the filter.
  typedef logic [7:0] qpss_sample_t;

  // Load measurement result width.
  typedef logic [9:0] qpss_load_t;

endpackage : qpss_pkg

// [design/qpss_regs.sv]
`timescale 1ns/10ps
`include "qpss_consts.svh"

// Functional notes
// RULE1 - Auto current scale reads in bits 24:16.
// RULE2 - Duty-cycle sum reads in bits 9:0.
// RULE3 - Coil currents scaled by duty-cycle sum.
// RULE4 - Sum 1023 means maximum duty cycle.
// RULE5 - Auto gradient reads in bits 23:16.
// RULE6 - Auto offset reads in bits 7:0.
// RULE7 - Bit 9 enables phase compensation, resets one.
// RULE8 - Bit 8 enables load filter, resets zero.
// RULE9 - Writable 8-bit stall threshold, bits 7:0.
// RULE10 - Stall when result not above threshold.
// RULE11 - Load result updates once per full step.
// RULE12 - Filter input samples readable while filtering.
// RULE13 - Unused bits read zero; status ignores writes.
module qpss_regs
  import qpss_pkg::*;
#(
  parameter int AW = 12, // APB address width.
  parameter int CW = 9 // Coil current width.
) (
  input wire logic core_clk_i, // Core clock, 250 MHz.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic psel_i, // APB select.
  input wire logic penable_i, // APB enable.
  input wire logic pwrite_i, // APB direction, high writes.
  input wire logic [AW-1:0] paddr_i, // APB byte address.
  input wire logic [31:0] pwdata_i, // APB write data.
  input wire logic [3:0] pstrb_i, // APB byte lane strobes.
  output logic [31:0] prdata_o, // APB read data.
  output logic pready_o, // APB ready.
  output logic pslverr_o, // APB error on unmapped address.
  input wire logic [8:0] auto_scale_i, // Auto current scale.
  input wire logic [9:0] duty_cycle_sum_i, // Duty-cycle sum.
  input wire logic [7:0] auto_gradient_i, // Auto tuned gradient.
  input wire logic [7:0] auto_offset_i, // Auto tuned offset.
  input wire logic [CW-1:0] sine_table_coil_a_i, // Coil A current.
  input wire logic [CW-1:0] sine_table_coil_b_i, // Coil B current.
  input wire logic full_step_i, // Full step pulse.
  input wire logic [9:0] load_measure_i, // Raw load measurement.
  output logic [CW-1:0] coil_a_scaled_o, // Scaled coil A current.
  output logic [CW-1:0] coil_b_scaled_o, // Scaled coil B current.
  output logic duty_at_max_o, // Duty cycle at maximum.
  output logic stall_o, // Stall detected.
  output logic phase_comp_enable_o, // Phase compensation on.
  output logic load_filter_enable_o // Load filter on.
);

  // Bus slave state and the stall setup fields.
  qpss_apb_st_t state_ff;
  logic [7:0] thr_ff;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic [9:0] word_idx;
  logic access;
  logic done;

  // The load detector sits behind this carrier.
  qpss_stall_if st_if ();

  // Word index of the access; the low two address bits are ignored.
  assign word_idx = 10'(paddr_i[AW-1:2]);

  // An access phase is waiting for its answer.
  assign access = psel_i && penable_i;

  // The transfer completes at the edge that sees ready high.
  assign done = access && pready_o;

  // Ready comes one cycle into the access phase, so read data is
  // captured from a stable flop rather than a live mux path.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= QPSS_ST_IDLE;
    end else begin
      unique case (state_ff)
        QPSS_ST_IDLE: begin
          // Access phase seen: answer in the next cycle.
          if (access) begin
            state_ff <= QPSS_ST_RESP;
          end
        end
        QPSS_ST_RESP: begin
          // Master has sampled ready, drop back.
          state_ff <= QPSS_ST_IDLE;
        end
      endcase
    end
  end

  // Ready is high for exactly one cycle per transfer.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= access && (state_ff == QPSS_ST_IDLE);
    end
  end

  // Read mux; every bit not named here reads as zero.
  always_comb begin
    nxt_rdata = `QPSS_STATUS_RST; // RULE13
    nxt_err = 1'b0;
    unique case (word_idx)
      `QPSS_IDX_SCALE: begin
        nxt_rdata[`QPSS_SCALE_AUTO_MSB:`QPSS_SCALE_AUTO_LSB] =
          auto_scale_i; // RULE1
        nxt_rdata[`QPSS_SUM_MSB:`QPSS_SUM_LSB] =
          duty_cycle_sum_i; // RULE2
      end
      `QPSS_IDX_AUTO: begin
        nxt_rdata[`QPSS_GRAD_MSB:`QPSS_GRAD_LSB] =
          auto_gradient_i; // RULE5
        nxt_rdata[`QPSS_OFS_MSB:`QPSS_OFS_LSB] =
          auto_offset_i; // RULE6
      end
      `QPSS_IDX_STALL: begin
        nxt_rdata[`QPSS_PHASE_BIT] = phase_comp_enable_o; // RULE7
        nxt_rdata[`QPSS_FILT_BIT] = load_filter_enable_o; // RULE8
        nxt_rdata[`QPSS_THR_MSB:`QPSS_THR_LSB] = thr_ff; // RULE9
      end
      `QPSS_IDX_RESULT: begin
        nxt_rdata[`QPSS_RESULT_MSB:`QPSS_RESULT_LSB] =
          st_if.result; // RULE11
      end
      `QPSS_IDX_SAMPLES: begin
        // Samples only mean something while the filter runs.
        if (load_filter_enable_o) begin // RULE12
          nxt_rdata = {st_if.samples[3], st_if.samples[2],
                       st_if.samples[1], st_if.samples[0]};
        end
      end
      default: begin
        // Unmapped words answer with an error and zero data.
        nxt_err = 1'b1;
      end
    endcase
  end

  // Read data and error are caught as ready rises.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= `QPSS_STATUS_RST;
      pslverr_o <= 1'b0;
    end else if (access && (state_ff == QPSS_ST_IDLE)) begin
      prdata_o <= pwrite_i ? `QPSS_STATUS_RST : nxt_rdata;
      pslverr_o <= nxt_err;
    end else begin
      prdata_o <= `QPSS_STATUS_RST;
      pslverr_o <= 1'b0;
    end
  end

  // The setup register takes writes on the completing edge only.
  // Writes to the status words fall through here and are dropped.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thr_ff <= `QPSS_THR_RST;
      phase_comp_enable_o <= `QPSS_PHASE_RST; // RULE7
      load_filter_enable_o <= `QPSS_FILT_RST; // RULE8
    end else if (done && pwrite_i && word_idx == `QPSS_IDX_STALL) begin
      if (pstrb_i[`QPSS_LANE_THR]) begin
        thr_ff <= pwdata_i[`QPSS_THR_MSB:`QPSS_THR_LSB]; // RULE9
      end
      if (pstrb_i[`QPSS_LANE_CTRL]) begin
        phase_comp_enable_o <= pwdata_i[`QPSS_PHASE_BIT]; // RULE7
        load_filter_enable_o <= pwdata_i[`QPSS_FILT_BIT]; // RULE8
      end
    end
  end

  // Full duty flag, registered so the output is a flop.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      duty_at_max_o <= 1'b0;
    end else begin
      duty_at_max_o <= (duty_cycle_sum_i == `QPSS_DUTY_MAX); // RULE4
    end
  end

  // Stall leaves the detector from its own flop.
  assign stall_o = st_if.stall; // RULE10

  // Setup and raw measurement travel to the detector.
  assign st_if.threshold = thr_ff; // RULE9
  assign st_if.filt_en = load_filter_enable_o;
  assign st_if.full_step = full_step_i;
  assign st_if.measure = load_measure_i;

  // Load detector: result per full step and stall compare.
  qpss_load_stall u_load_stall (
    .clk_i (core_clk_i),
    .rstn_i (rstn_i),
    .st (st_if.det)
  );

  // Both coils use the same scaler; the duty sum is shared.
  qpss_coil_scale #(
    .CW (CW),
    .DW (10)
  ) u_coil_a (
    .clk_i (core_clk_i),
    .rstn_i (rstn_i),
    .cur_i (sine_table_coil_a_i),
    .duty_i (duty_cycle_sum_i),
    .scaled_o (coil_a_scaled_o)
  );

  // Second coil scaler.
  qpss_coil_scale #(
    .CW (CW),
    .DW (10)
  ) u_coil_b (
    .clk_i (core_clk_i),
    .rstn_i (rstn_i),
    .cur_i (sine_table_coil_b_i),
    .duty_i (duty_cycle_sum_i),
    .scaled_o (coil_b_scaled_o)
  );

  // All checks below run on the core clock and are off during reset.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_scale_read: assert property ( // RULE1
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_SCALE |=>
    prdata_o[24:16] == $past(auto_scale_i) &&
    prdata_o[31:25] == 7'h00
  ) else $error("auto scale field read wrong");

  a_sum_read: assert property ( // RULE2
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_SCALE |=>
    prdata_o[9:0] == $past(duty_cycle_sum_i) &&
    prdata_o[15:10] == 6'h00
  ) else $error("duty sum field read wrong");

  a_duty_max: assert property ( // RULE4
    duty_cycle_sum_i == 10'h3ff |=> duty_at_max_o
  ) else $error("full duty not flagged");

  a_auto_read: assert property ( // RULE5 RULE6
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_AUTO |=>
    prdata_o[23:16] == $past(auto_gradient_i) &&
    prdata_o[7:0] == $past(auto_offset_i) &&
    prdata_o[15:8] == 8'h00
  ) else $error("auto tuning fields read wrong");

  a_phase_write: assert property ( // RULE7
    done && pwrite_i && word_idx == `QPSS_IDX_STALL && pstrb_i[1] |=>
    phase_comp_enable_o == $past(pwdata_i[9])
  ) else $error("phase compensation bit not written");

  a_filter_write: assert property ( // RULE8
    done && pwrite_i && word_idx == `QPSS_IDX_STALL && pstrb_i[1] |=>
    load_filter_enable_o == $past(pwdata_i[8])
  ) else $error("filter enable bit not written");

  a_thr_write: assert property ( // RULE9
    done && pwrite_i && word_idx == `QPSS_IDX_STALL && pstrb_i[0] |=>
    thr_ff == $past(pwdata_i[7:0])
  ) else $error("stall threshold not written");

  a_setup_hold: assert property ( // RULE13
    !(done && pwrite_i && word_idx == `QPSS_IDX_STALL) |=>
    $stable(thr_ff) && $stable(phase_comp_enable_o) &&
    $stable(load_filter_enable_o)
  ) else $error("setup register changed without a write");

  a_samples_gate: assert property ( // RULE12
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_SAMPLES && !load_filter_enable_o |=>
    prdata_o == 32'h0000_0000
  ) else $error("samples shown with filter off");

  a_ready_pulse: assert property (
    access && !pready_o && state_ff == QPSS_ST_IDLE |=>
    pready_o ##1 !pready_o
  ) else $error("ready not a single cycle after one wait");

  // Ready answers only an access phase that was seen while idle.
  a_ready_cause: assert property (
    pready_o |-> $past(access) && $past(state_ff) == QPSS_ST_IDLE
  ) else $error("ready without a preceding access phase");

  // Outside the answering cycle the bus sees zero data and no error,
  // which keeps a bus-level OR of several slaves clean.
  a_idle_quiet: assert property (
    !pready_o |-> prdata_o == `QPSS_STATUS_RST && !pslverr_o
  ) else $error("read data or error outside a ready cycle");

  // An unmapped word answers with an error and no data, so a stray
  // pointer in host software shows up instead of reading as zero.
  a_unmapped_err: assert property ( // RULE13
    access && state_ff == QPSS_ST_IDLE &&
    (word_idx < `QPSS_IDX_SCALE || word_idx > `QPSS_IDX_SAMPLES) |=>
    pslverr_o && prdata_o == `QPSS_STATUS_RST
  ) else $error("unmapped word not refused");

  // Every mapped word answers without an error flag.
  a_mapped_ok: assert property ( // RULE13
    access && state_ff == QPSS_ST_IDLE &&
    word_idx >= `QPSS_IDX_SCALE && word_idx <= `QPSS_IDX_SAMPLES |=>
    !pslverr_o
  ) else $error("error raised on a mapped word");

  // The result word carries the detector result, zeros above it.
  a_result_read: assert property ( // RULE11
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_RESULT |=>
    prdata_o[9:0] == $past(st_if.result) && prdata_o[31:10] == 22'h0
  ) else $error("load result read wrong");

  // With the filter on, the samples word shows the history.
  a_samples_read: assert property ( // RULE12
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_SAMPLES && load_filter_enable_o |=>
    prdata_o == {$past(st_if.samples[3]), $past(st_if.samples[2]),
                 $past(st_if.samples[1]), $past(st_if.samples[0])}
  ) else $error("filter samples read wrong");

  // The setup word reads back what was stored, zeros elsewhere.
  a_setup_read: assert property ( // RULE9
    access && !pwrite_i && state_ff == QPSS_ST_IDLE &&
    word_idx == `QPSS_IDX_STALL |=>
    prdata_o == {22'h0, $past(phase_comp_enable_o),
                 $past(load_filter_enable_o), $past(thr_ff)}
  ) else $error("stall setup read wrong");

  // The stall level lags the result by one edge. The check starts
  // only once reset is seen released, since the flop still holds its
  // reset value at the first edge and would not compare.
  a_stall_out: assert property ( // RULE10
    rstn_i |=>
    stall_o == ($past(st_if.result) <= {2'b00, $past(thr_ff)})
  ) else $error("stall output does not follow result and threshold");

endmodule : qpss_regs

// [design/qpss_stall_if.sv]
`timescale 1ns/10ps
// Carries the stall setup to the load detector and its state back.
interface qpss_stall_if;
  import qpss_pkg::*;
  logic [7:0] threshold; // Programmed stall threshold.
  logic filt_en; // Load filter enable.
  logic full_step; // One pulse per full step.
  qpss_load_t measure; // Raw load measurement.
  qpss_load_t result; // Load measurement result.
  qpss_sample_t samples [4]; // Filter input samples.
  logic stall; // Stall indication.

  modport cfg (
    output threshold, filt_en, full_step, measure,
    input result, samples, stall
  );
  modport det (
    input threshold, filt_en, full_step, measure,
    output result, samples, stall
  );
endinterface : qpss_stall_if

// [sim/qpss_regs_tb.sv]
`timescale 1ns/10ps
`include "qpss_consts.svh"
// Self-checking bench for the register slice, driven over APB.
module qpss_regs_tb
  import qpss_pkg::*;
;
  localparam logic [11:0] A_SCALE = {`QPSS_IDX_SCALE, 2'b00};
  localparam logic [11:0] A_AUTO = {`QPSS_IDX_AUTO, 2'b00};
  localparam logic [11:0] A_STALL = {`QPSS_IDX_STALL, 2'b00};
  localparam logic [11:0] A_RES = {`QPSS_IDX_RESULT, 2'b00};
  localparam logic [11:0] A_SMP = {`QPSS_IDX_SAMPLES, 2'b00};
  localparam logic [11:0] A_BAD = 12'h1dc; // First word past the last register.

  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd; // The last read data lands in rd.
  logic [3:0] pstrb;
  logic [8:0] auto_scale, coil_a, coil_b, a_scaled, b_scaled;
  logic [9:0] duty_sum, measure;
  logic [7:0] gradient, offset;
  logic full_step, at_max, stall, phase_en, filt_en;
  int error_cnt, checks_done;

  qpss_regs i_qpss_regs (
    .core_clk_i(core_clk), .rstn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .auto_scale_i(auto_scale),
    .duty_cycle_sum_i(duty_sum), .auto_gradient_i(gradient),
    .auto_offset_i(offset), .sine_table_coil_a_i(coil_a),
    .sine_table_coil_b_i(coil_b), .full_step_i(full_step),
    .load_measure_i(measure), .coil_a_scaled_o(a_scaled),
    .coil_b_scaled_o(b_scaled), .duty_at_max_o(at_max),
    .stall_o(stall), .phase_comp_enable_o(phase_en),
    .load_filter_enable_o(filt_en)
  );

  // The clock toggles every 2 ns for a 250 MHz rate.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer, entered just after a rising edge. It leaves the
  // request up so that another transfer may follow at once.
  task automatic apb(input logic wr, input logic [11:0] addr,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    pstrb <= st;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("ERROR pready expected 1 seen %b", pready);
      finish_test();
    end else begin
      rd = prdata;
      err = pslverr;
    end
  endtask : apb

  // Releases the bus for one cycle.
  task automatic apb_idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb_idle

  // One full step; result lands at the next edge, stall one edge later.
  task automatic step(input logic [9:0] m);
    measure <= m;
    full_step <= 1'b1;
    @(posedge core_clk);
    full_step <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : step

  // Reset values of every register but the samples word, and of the setup outputs.
  task automatic t_reset();
    check("phase_en", phase_en, 32'h1);
    check("filt_en", filt_en, 32'h0);
    apb(1'b0, A_SCALE, 32'h0, 4'h0);
    check("scale_rst", rd, 32'h0);
    apb(1'b0, A_AUTO, 32'h0, 4'h0);
    check("auto_rst", rd, 32'h0);
    apb(1'b0, A_STALL, 32'h0, 4'h0);
    check("stall_rst", rd, 32'h0000_0200);
    apb(1'b0, A_RES, 32'h0, 4'h0);
    check("result_rst", rd, 32'h0);
    apb_idle();
  endtask : t_reset

  // Status words follow their inputs and shrug off writes.
  task automatic t_status();
    for (int i = 0; i < 2; i++) begin
      auto_scale <= (i == 0) ? 9'h101 : 9'h1ff;
      duty_sum <= (i == 0) ? 10'h3fe : 10'h3ff;
      gradient <= (i == 0) ? 8'h5a : 8'ha5;
      offset <= (i == 0) ? 8'ha5 : 8'h5a;
      apb(1'b1, A_SCALE, 32'hffff_ffff, 4'hf);
      apb(1'b0, A_SCALE, 32'h0, 4'h0);
      check("scale", rd,
            {7'h0, auto_scale, 6'h0, duty_sum});
      apb(1'b1, A_AUTO, 32'hffff_ffff, 4'hf);
      apb(1'b0, A_AUTO, 32'h0, 4'h0);
      check("auto", rd, {8'h0, gradient, 8'h0, offset});
      check("at_max", at_max, {31'h0, duty_sum == 10'h3ff});
      apb_idle();
    end
  endtask : t_status

  // Coil currents are scaled by the duty sum, low ten bits dropped.
  task automatic t_scale();
    logic [9:0] d[3] = '{10'h3ff, 10'h200, 10'h001};
    logic [18:0] pa, pb;
    coil_a <= 9'h1ff;
    coil_b <= 9'h100;
    for (int i = 0; i < 3; i++) begin
      duty_sum <= d[i];
      repeat (3) @(posedge core_clk);
      pa = coil_a * d[i];
      pb = coil_b * d[i];
      check("coil_a", a_scaled, {23'h0, pa[18:10]});
      check("coil_b", b_scaled, {23'h0, pb[18:10]});
    end
  endtask : t_scale

  // Setup word: lanes, unused bits and an unmapped word.
  task automatic t_cfg();
    apb(1'b1, A_STALL, 32'hffff_ffff, 4'hf);
    apb(1'b0, A_STALL, 32'h0, 4'h0);
    check("cfg_all", rd, 32'h0000_03ff);
    apb(1'b1, A_STALL, 32'h0, 4'h2);
    apb(1'b0, A_STALL, 32'h0, 4'h0);
    check("cfg_lane1", rd, 32'h0000_00ff);
    check("phase_off", phase_en, 32'h0);
    apb(1'b1, A_STALL, 32'h0000_0340, 4'h1);
    apb(1'b1, A_BAD, 32'hffff_ffff, 4'hf);
    check("bad_wr_err", err, 32'h1);
    apb(1'b0, A_BAD, 32'h0, 4'h0);
    check("bad_rd_err", err, 32'h1);
    check("bad_rd", rd, 32'h0);
    apb(1'b0, A_STALL, 32'h0, 4'h0);
    check("cfg_lane0", rd, 32'h0000_0040);
    check("good_err", err, 32'h0);
    apb_idle();
  endtask : t_cfg

  // Stall compare against threshold 0x40 with the filter off.
  task automatic t_load();
    logic [9:0] m[4] = '{10'h041, 10'h040, 10'h03f, 10'h140};
    logic ex[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      step(m[i]);
      check("stall", stall, {31'h0, ex[i]});
    end
    // A new measurement without a full step must not be taken.
    measure <= 10'h000;
    repeat (3) @(posedge core_clk);
    check("stall_hold", stall, 32'h0);
    apb(1'b0, A_RES, 32'h0, 4'h0);
    check("result", rd, 32'h0000_0140);
    apb(1'b0, A_SMP, 32'h0, 4'h0);
    check("smp_off", rd, 32'h0);
    apb_idle();
  endtask : t_load

  // Four back-to-back full steps through the load filter.
  task automatic t_filter();
    apb(1'b1, A_STALL, 32'h0000_01ff, 4'h3);
    apb_idle();
    check("filt_on", filt_en, 32'h1);
    for (int i = 0; i < 4; i++) begin
      measure <= 10'((i + 1) * 64);
      full_step <= 1'b1;
      @(posedge core_clk);
    end
    full_step <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("stall_filt", stall, 32'h1);
    apb(1'b0, A_SMP, 32'h0, 4'h0);
    check("samples", rd, 32'h1020_3040);
    apb(1'b0, A_RES, 32'h0, 4'h0);
    check("result_filt", rd, 32'h0000_00a0);
    apb(1'b1, A_STALL, 32'h0, 4'h2);
    apb(1'b0, A_SMP, 32'h0, 4'h0);
    check("smp_hidden", rd, 32'h0);
    apb_idle();
  endtask : t_filter

  // Main sequence: all inputs known at time zero, reset for 4 cycles.
  initial begin
    error_cnt = 0;
    checks_done = 0;
    rstn = 1'b0;
    {psel, penable, pwrite, full_step} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {auto_scale, coil_a, coil_b} = 27'h0;
    {duty_sum, measure} = 20'h0;
    {gradient, offset} = 16'h0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_status();
    t_scale();
    t_cfg();
    t_load();
    t_filter();
    finish_test();
  end
endmodule : qpss_regs_tb
